// *** acl_pkg.sv ***
// Shared constants and types for the link reset and clock logic
// =====================================================================
// How it works
// - Codec floats clock and data during reset
// - Controller holds cold reset low 1.0 us
// - Clock starts 0.01628 to 400 us after release
// - Codec drives outputs soon after reset release
// - No reset until clock active 0.416 us
// - Warm reset: SYNC high at least 1.0 us
// - Clock restarts 162.8 ns after warm pulse
// - Clock phases each 36 to 45 ns
// - Clock duty cycle within 45/55
// - One 48 kHz frame, SYNC mostly low
// - Frame SYNC high sixteen clock periods
// - Link low at release; data high selects test
package acl_pkg;

  // =====================================================================
  // Clock and printed times
  localparam real SYS_PERIOD_NS = 40.0;
  localparam real TRES_LOW_MIN_US = 1.0;
  localparam real TRI2ACTV_MAX_NS = 25.0;
  localparam real TRST2CLK_MIN_US = 0.01628;
  localparam real TRST2CLK_MAX_US = 400.0;
  localparam real TCLK2RST_MIN_US = 0.416;
  localparam real TSYNC_HIGH_MIN_US = 1.0;
  localparam real TSYNC_HIGH_TYP_US = 1.3;
  localparam real TSYNC2CLK_MIN_NS = 162.8;
  localparam real TCLK_PHASE_MIN_NS = 36.0;
  localparam real TCLK_PHASE_MAX_NS = 45.0;
  localparam real BIT_CLK_TYP_MHZ = 12.288;
  localparam real SYNC_RATE_TYP_KHZ = 48.0;
  localparam real TSYNC_LOW_TYP_US = 19.5;

  function automatic int ns_to_cyc(input real ns, input bit round_up);
    int c;
    c = int'(ns / SYS_PERIOD_NS);
    if (round_up && (real'(c) * SYS_PERIOD_NS < ns)) c = c + 1;
    if (!round_up && (real'(c) * SYS_PERIOD_NS > ns)) c = c - 1;
    if (c < 1) c = 1;
    return c;
  endfunction

  // =====================================================================
  // Cycle counts at clk_sys
  localparam logic [5:0] TRES_LOW_CYC = 6'(ns_to_cyc(TRES_LOW_MIN_US * 1000.0, 1'b1));
  localparam logic [5:0] TRST2CLK_MIN_CYC = 6'(ns_to_cyc(TRST2CLK_MIN_US * 1000.0, 1'b1));
  localparam logic [5:0] TCLK2RST_CYC = 6'(ns_to_cyc(TCLK2RST_MIN_US * 1000.0, 1'b1));
  localparam logic [5:0] WARM_MIN_CYC = 6'(ns_to_cyc(TSYNC_HIGH_MIN_US * 1000.0, 1'b1));
  localparam logic [5:0] WARM_PULSE_CYC = 6'(ns_to_cyc(TSYNC_HIGH_TYP_US * 1000.0, 1'b1));
  localparam logic [5:0] TSYNC2CLK_CYC = 6'(ns_to_cyc(TSYNC2CLK_MIN_NS, 1'b1));
  localparam logic [1:0] CLK_PHASE_CYC = 2'(ns_to_cyc(TCLK_PHASE_MAX_NS, 1'b0));
  // Two synchroniser stages plus the sampling edge for the test strap
  localparam logic [5:0] STRAP_CYC = 6'h03;
  localparam logic [5:0] START_CYC = (TRST2CLK_MIN_CYC > STRAP_CYC) ? TRST2CLK_MIN_CYC : STRAP_CYC;
  // Link clock counted as stopped after this many cycles without an edge
  localparam logic [3:0] CLK_IDLE_CYC = 4'h8;

  // =====================================================================
  // Frame layout in link clock periods
  localparam logic [7:0] FRAME_LAST_BIT = 8'hFF;
  localparam logic [7:0] SYNC_HIGH_BITS = 8'h10;

  // =====================================================================
  // State machines
  typedef enum logic [2:0] {
    ACL_OFF = 3'h0,
    ACL_START = 3'h1,
    ACL_RUN = 3'h3,
    ACL_PARK = 3'h2,
    ACL_WAKE = 3'h6,
    ACL_TEST = 3'h4
  } acl_cst_t;

  typedef enum logic [1:0] {
    ACL_C_RST = 2'h0,
    ACL_C_RUN = 2'h1,
    ACL_C_WARM = 2'h3
  } acl_hst_t;

endpackage

// *** acl_link_if.sv ***
// Five-wire link between controller and codec
`timescale 1ns/1ps
`default_nettype none
interface acl_link_if;
  logic reset_b;
  logic sync;
  logic sdata_out;
  logic bit_clk_drv;
  logic bit_clk_oe;
  logic sdata_in_drv;
  logic sdata_in_oe;
  logic bit_clk;
  logic sdata_in;

  // A floating line is seen low, as with the usual weak pull-down
  assign bit_clk = bit_clk_oe & bit_clk_drv;
  assign sdata_in = sdata_in_oe & sdata_in_drv;

  modport codec(
    input reset_b, sync, sdata_out,
    output bit_clk_drv, bit_clk_oe, sdata_in_drv, sdata_in_oe
  );
  modport ctrl(
    output reset_b, sync, sdata_out,
    input bit_clk, sdata_in
  );
endinterface
`default_nettype wire

// *** acl_codec.sv ***
// Codec end: reset handling, bit clock generation and warm wake-up
`timescale 1ns/1ps
`default_nettype none
module acl_codec (
  input wire logic clk_sys,
  input wire logic rst_b,
  acl_link_if.codec lnk,
  input wire logic clk_stop_req,
  output logic clk_running,
  output logic test_mode,
  output logic warm_wake
);

  // =====================================================================
  // Reset
  // The link reset line acts at once, without the clock, so the pins
  // float for the whole time it is low.
  logic arst_b;
  assign arst_b = rst_b & lnk.reset_b;

  // =====================================================================
  // Pin synchronisers
  // Bit 0 is SYNC, bit 1 is serial data out.
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_raw;
  assign pin_raw = {lnk.sdata_out, lnk.sync};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      always_ff @(posedge clk_sys or negedge arst_b) begin
        if (!arst_b) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic sync_in;
  logic strap_in;
  assign sync_in = pin_sync[0];
  assign strap_in = pin_sync[1];

  // =====================================================================
  // State and counters
  acl_pkg::acl_cst_t state;
  acl_pkg::acl_cst_t next_state;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [1:0] ph_cnt;
  logic [1:0] next_ph_cnt;
  logic bclk;
  logic next_bclk;
  logic bclk_oe;
  logic next_oe;

  // =====================================================================
  // Decodes
  logic ph_end;
  logic start_done;
  logic warm_long;
  logic wake_done;
  logic cnt_full;
  logic park_ok;

  assign ph_end = (ph_cnt == (acl_pkg::CLK_PHASE_CYC - 2'h1));
  assign start_done = (cnt == (acl_pkg::START_CYC - 6'h01));
  assign warm_long = (cnt >= acl_pkg::WARM_MIN_CYC);
  assign wake_done = (cnt == (acl_pkg::TSYNC2CLK_CYC - 6'h01));
  assign cnt_full = (cnt == 6'h3F);
  // Park only on a falling half so that no runt high phase reaches the pin
  assign park_ok = clk_stop_req & bclk & ph_end;

  // =====================================================================
  // Next state
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      acl_pkg::ACL_OFF: begin
        next_state = acl_pkg::ACL_START;
        // The first edge after release counts, so the strap is decided while still synchronised high
        next_cnt = 6'h01;
      end
      acl_pkg::ACL_START: begin
        next_cnt = cnt + 6'h01;
        if (start_done) begin
          next_cnt = 6'h00;
          // Serial data out high at release selects the floating test mode
          next_state = strap_in ? acl_pkg::ACL_TEST : acl_pkg::ACL_RUN;
        end
      end
      acl_pkg::ACL_RUN: begin
        next_cnt = 6'h00;
        if (park_ok) begin
          next_state = acl_pkg::ACL_PARK;
        end
      end
      acl_pkg::ACL_PARK: begin
        if (sync_in) begin
          next_cnt = cnt_full ? cnt : cnt + 6'h01;
        end else if (warm_long) begin
          next_cnt = 6'h00;
          next_state = acl_pkg::ACL_WAKE;
        end else begin
          // A pulse too short for a warm reset is forgotten
          next_cnt = 6'h00;
        end
      end
      acl_pkg::ACL_WAKE: begin
        next_cnt = cnt + 6'h01;
        if (wake_done) begin
          next_cnt = 6'h00;
          next_state = acl_pkg::ACL_RUN;
        end
      end
      acl_pkg::ACL_TEST: begin
        // Left only through another cold reset
        next_cnt = 6'h00;
      end
      default: begin
        next_state = acl_pkg::ACL_OFF;
        next_cnt = 6'h00;
      end
    endcase
  end

  // =====================================================================
  // Bit clock divider
  // One clk_sys period per phase gives 40 ns high and 40 ns low, a
  // period of 80 ns; the nominal 81.4 ns is not reachable from 25 MHz.
  always_comb begin
    next_ph_cnt = 2'h0;
    next_bclk = 1'b0;
    if (state == acl_pkg::ACL_RUN) begin
      next_ph_cnt = ph_end ? 2'h0 : ph_cnt + 2'h1;
      next_bclk = ph_end ? ~bclk : bclk;
    end
  end

  // Drivers turn on at the first edge after release and stay on except in test
  assign next_oe = (next_state != acl_pkg::ACL_OFF) && (next_state != acl_pkg::ACL_TEST);

  // =====================================================================
  // Registers
  always_ff @(posedge clk_sys or negedge arst_b) begin
    if (!arst_b) begin
      state <= acl_pkg::ACL_OFF;
      cnt <= 6'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_b) begin
    if (!arst_b) begin
      ph_cnt <= 2'h0;
      bclk <= 1'b0;
    end else begin
      ph_cnt <= next_ph_cnt;
      bclk <= next_bclk;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_b) begin
    if (!arst_b) begin
      bclk_oe <= 1'b0;
    end else begin
      bclk_oe <= next_oe;
    end
  end

  // =====================================================================
  // User-side status
  always_ff @(posedge clk_sys or negedge arst_b) begin
    if (!arst_b) begin
      clk_running <= 1'b0;
      test_mode <= 1'b0;
      warm_wake <= 1'b0;
    end else begin
      clk_running <= (next_state == acl_pkg::ACL_RUN);
      test_mode <= (next_state == acl_pkg::ACL_TEST);
      warm_wake <= (state == acl_pkg::ACL_WAKE) && (next_state == acl_pkg::ACL_RUN);
    end
  end

  // =====================================================================
  // Pins
  // Slot payload is handled elsewhere; the data line is held low here.
  assign lnk.bit_clk_drv = bclk;
  assign lnk.bit_clk_oe = bclk_oe;
  assign lnk.sdata_in_drv = 1'b0;
  assign lnk.sdata_in_oe = bclk_oe;

endmodule
`default_nettype wire

// *** acl_ctrl.sv ***
// Controller end: cold and warm reset, frame SYNC on the link clock
`timescale 1ns/1ps
`default_nettype none
module acl_ctrl (
  input wire logic clk_sys,
  input wire logic rst_b,
  acl_link_if.ctrl lnk,
  input wire logic cold_req,
  input wire logic warm_req,
  input wire logic test_req,
  output logic link_alive,
  output logic busy,
  output logic refused
);

  // =====================================================================
  // Link domain, clocked by the codec's bit clock
  logic rst_out_b;
  logic lrst_meta;
  logic lrst_sync;
  logic [7:0] bit_cnt;
  logic frame_hi;
  logic tgl;

  // Held in reset while the link reset line is low; release is synchronised
  always_ff @(posedge lnk.bit_clk or negedge rst_out_b) begin
    if (!rst_out_b) begin
      lrst_meta <= 1'b0;
      lrst_sync <= 1'b0;
    end else begin
      lrst_meta <= 1'b1;
      lrst_sync <= lrst_meta;
    end
  end

  always_ff @(posedge lnk.bit_clk or negedge rst_out_b) begin
    if (!rst_out_b) begin
      bit_cnt <= 8'h00;
      frame_hi <= 1'b0;
      tgl <= 1'b0;
    end else begin
      bit_cnt <= (lrst_sync && bit_cnt != acl_pkg::FRAME_LAST_BIT) ? bit_cnt + 8'h01 : 8'h00;
      frame_hi <= lrst_sync && (bit_cnt < acl_pkg::SYNC_HIGH_BITS);
      tgl <= ~tgl;
    end
  end

  // =====================================================================
  // Crossings into clk_sys
  logic fr_meta;
  logic fr_sync;
  logic tgl_meta;
  logic tgl_sync;
  logic tgl_dly;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fr_meta <= 1'b0;
      fr_sync <= 1'b0;
      tgl_meta <= 1'b0;
      tgl_sync <= 1'b0;
      tgl_dly <= 1'b0;
    end else begin
      fr_meta <= frame_hi;
      fr_sync <= fr_meta;
      tgl_meta <= tgl;
      tgl_sync <= tgl_meta;
      tgl_dly <= tgl_sync;
    end
  end

  // =====================================================================
  // Link clock activity
  logic [3:0] idle_cnt;
  logic [5:0] act_cnt;
  logic clk_edge;
  logic alive;
  logic act_done;
  logic cold_ok;

  assign clk_edge = tgl_sync ^ tgl_dly;
  assign alive = (idle_cnt != acl_pkg::CLK_IDLE_CYC);
  assign act_done = (act_cnt >= acl_pkg::TCLK2RST_CYC);
  // A dead codec may always be reset; a live clock must have run long enough
  assign cold_ok = ~alive | act_done;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt <= acl_pkg::CLK_IDLE_CYC;
      act_cnt <= 6'h00;
    end else begin
      idle_cnt <= clk_edge ? 4'h0 : (alive ? idle_cnt + 4'h1 : idle_cnt);
      act_cnt <= !alive ? 6'h00 : (act_done ? act_cnt : act_cnt + 6'h01);
    end
  end

  // =====================================================================
  // Reset sequencer
  acl_pkg::acl_hst_t state;
  acl_pkg::acl_hst_t next_state;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic test_sel;
  logic cold_go;
  logic warm_go;
  logic rst_done;
  logic warm_done;

  assign cold_go = cold_req && cold_ok && (state == acl_pkg::ACL_C_RUN);
  // Warm reset only wakes a stopped clock; a running one would collide with frames
  assign warm_go = warm_req && !cold_req && !alive && (state == acl_pkg::ACL_C_RUN);
  assign rst_done = (cnt == (acl_pkg::TRES_LOW_CYC - 6'h01));
  assign warm_done = (cnt == (acl_pkg::WARM_PULSE_CYC - 6'h01));

  always_comb begin
    next_state = state;
    next_cnt = cnt + 6'h01;
    unique case (state)
      acl_pkg::ACL_C_RST: begin
        if (rst_done) begin
          next_state = acl_pkg::ACL_C_RUN;
          next_cnt = 6'h00;
        end
      end
      acl_pkg::ACL_C_RUN: begin
        next_cnt = 6'h00;
        if (cold_go) begin
          next_state = acl_pkg::ACL_C_RST;
        end else if (warm_go) begin
          next_state = acl_pkg::ACL_C_WARM;
        end
      end
      acl_pkg::ACL_C_WARM: begin
        if (warm_done) begin
          next_state = acl_pkg::ACL_C_RUN;
          next_cnt = 6'h00;
        end
      end
      default: begin
        next_state = acl_pkg::ACL_C_RST;
        next_cnt = 6'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= acl_pkg::ACL_C_RST;
      cnt <= 6'h00;
      test_sel <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      test_sel <= cold_go ? test_req : test_sel;
    end
  end

  // =====================================================================
  // Link pins and status
  logic sync_o;
  logic sdo;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_out_b <= 1'b0;
      sync_o <= 1'b0;
      sdo <= 1'b0;
      link_alive <= 1'b0;
      busy <= 1'b1;
      refused <= 1'b0;
    end else begin
      rst_out_b <= (next_state != acl_pkg::ACL_C_RST);
      // SYNC low in reset; frames only in run
      sync_o <= (next_state == acl_pkg::ACL_C_WARM) || (fr_sync && next_state == acl_pkg::ACL_C_RUN);
      // Data out high across the release edge only when test is chosen
      sdo <= test_sel && (state == acl_pkg::ACL_C_RST);
      link_alive <= alive && act_done;
      busy <= (next_state != acl_pkg::ACL_C_RUN);
      refused <= (cold_req && !cold_go) || (warm_req && !cold_go && !warm_go);
    end
  end

  assign lnk.reset_b = rst_out_b;
  assign lnk.sync = sync_o;
  assign lnk.sdata_out = sdo;

endmodule
`default_nettype wire

// *** acl_assertions.sv ***
// Timing checker on the shared link wires
`timescale 1ns/1ps
`default_nettype none
module acl_assertions (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reset_b,
  input wire logic sync,
  input wire logic sdata_out,
  input wire logic bit_clk_oe,
  input wire logic sdata_in_oe,
  input wire logic bit_clk
);
  // =====================================================================
  // Helper counters
  logic prev_clk;
  logic [5:0] low_cnt;
  logic [5:0] hi_cnt;
  logic [8:0] lo_cnt;
  logic [3:0] idle_cnt;
  logic [3:0] act_cnt;
  logic lo_ok;
  wire chg = bit_clk != prev_clk;
  wire stopped = idle_cnt >= 4'h8;

  // Saturating, so a long park cannot wrap into a false frame length
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_clk <= 1'b0;
      low_cnt <= 6'h00;
      hi_cnt <= 6'h00;
      lo_cnt <= 9'h000;
      idle_cnt <= 4'h0;
      act_cnt <= 4'h0;
      lo_ok <= 1'b0;
    end else begin
      prev_clk <= bit_clk;
      low_cnt <= reset_b ? 6'h00 : low_cnt + {5'h00, low_cnt != 6'h3F};
      hi_cnt <= sync ? hi_cnt + {5'h00, hi_cnt != 6'h3F} : 6'h00;
      lo_cnt <= (sync || !reset_b) ? 9'h000 : lo_cnt + {8'h00, lo_cnt != 9'h1FF};
      idle_cnt <= chg ? 4'h0 : idle_cnt + {3'h0, idle_cnt != 4'hF};
      act_cnt <= stopped ? 4'h0 : act_cnt + {3'h0, chg && act_cnt != 4'hF};
      // A low time begun by a warm pulse or a park is not a whole frame
      lo_ok <= (!reset_b || stopped) ? 1'b0 : (sync ? 1'b1 : lo_ok);
    end
  end

  // =====================================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  float_reset_a: assert property (!reset_b |-> !bit_clk_oe && !sdata_in_oe)
    else $error("link outputs driven during reset");
  cold_width_a: assert property ($rose(reset_b) |-> low_cnt >= 6'h19)
    else $error("cold reset pulse too short");
  clk_start_a: assert property ($rose(reset_b) && !sdata_out |-> !bit_clk ##[1:12] bit_clk)
    else $error("bit clock start outside window");
  drive_release_a: assert property ($rose(reset_b) && !sdata_out |-> ##1 bit_clk_oe && sdata_in_oe)
    else $error("outputs not driven after release");
  clk_settle_a: assert property ($fell(reset_b) |-> act_cnt == 4'h0 || act_cnt >= 4'hB || idle_cnt >= 4'h6)
    else $error("reset while bit clock just started");
  sync_width_a: assert property ($fell(sync) && reset_b |-> hi_cnt >= 6'h19)
    else $error("sync pulse too short");
  warm_restart_a: assert property ($fell(sync) && stopped |-> !bit_clk [*5] ##[1:8] bit_clk)
    else $error("bit clock restart timing after warm pulse");
  clk_phase_a: assert property ($rose(bit_clk) |=> $fell(bit_clk))
    else $error("bit clock high phase wrong");
  frame_high_a: assert property ($fell(sync) && reset_b && act_cnt >= 4'hB |-> hi_cnt >= 6'h1F && hi_cnt <= 6'h21)
    else $error("frame sync high length wrong");
  frame_low_a: assert property ($rose(sync) && lo_ok && act_cnt >= 4'hB && lo_cnt >= 9'h12C
      |-> lo_cnt >= 9'h1DE && lo_cnt <= 9'h1E2)
    else $error("frame sync low length wrong");
  test_float_a: assert property ($rose(reset_b) && sdata_out |-> ##5 !bit_clk_oe && !sdata_in_oe)
    else $error("test strap did not float outputs");
  quiet_release_a: assert property ($rose(reset_b) |-> !sync)
    else $error("sync high at reset release");
endmodule
`default_nettype wire

// *** aclink_reset_and_clock_timing_tb.sv ***
// Self-checking bench: cold, warm, park and test resets across the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module aclink_reset_and_clock_timing_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic clk_stop_req = 1'b0;
  logic cold_req = 1'b0;
  logic warm_req = 1'b0;
  logic test_req = 1'b0;
  logic clk_running, test_mode, warm_wake, link_alive, busy, refused;
  logic t;
  logic [1:0] exp_n;
  logic [1:0] notes[$];
  int failures = 0;
  int num_checks = 0;

  acl_link_if lnk_if();
  acl_codec acl_codec_inst (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(lnk_if), .clk_stop_req(clk_stop_req),
    .clk_running(clk_running), .test_mode(test_mode), .warm_wake(warm_wake));
  acl_ctrl acl_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(lnk_if), .cold_req(cold_req),
    .warm_req(warm_req), .test_req(test_req), .link_alive(link_alive), .busy(busy), .refused(refused));
  acl_assertions acl_assertions_inst (.clk_sys(clk_sys), .rst_b(rst_b), .reset_b(lnk_if.reset_b),
    .sync(lnk_if.sync), .sdata_out(lnk_if.sdata_out), .bit_clk_oe(lnk_if.bit_clk_oe),
    .sdata_in_oe(lnk_if.sdata_in_oe), .bit_clk(lnk_if.bit_clk));

  always #20 clk_sys = ~clk_sys;

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return busy;
      1: return clk_running;
      2: return link_alive;
      default: return lnk_if.sync;
    endcase
  endfunction

  task automatic wait_for(input int s, input logic v);
    int n;
    for (n = 0; n < 3000 && sig(s) !== v; n++) begin
      @(negedge clk_sys);
    end
    if (n == 3000) begin
      failures++;
      close_out();
    end
  endtask

  // Request pulse; 1 means refusal expected, 2 a warm wake-up
  task automatic pulse(input int s, input logic tst, input logic [1:0] exp);
    @(negedge clk_sys);
    cold_req = (s == 0);
    warm_req = (s == 1);
    test_req = tst;
    if (exp != 2'h0) begin
      notes.push_back(exp);
    end
    @(negedge clk_sys);
    cold_req = 1'b0;
    warm_req = 1'b0;
    test_req = 1'b0;
  endtask

  // =====================================================================
  // Pulse monitor
  always @(negedge clk_sys) begin
    if (rst_b && (refused === 1'b1 || warm_wake === 1'b1)) begin
      exp_n = (notes.size() > 0) ? notes.pop_front() : 2'h0;
      `CHK({warm_wake, refused}, exp_n)
    end
  end

  // =====================================================================
  // Main sequence
  initial begin
    void'($urandom(48908));
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    wait_for(0, 1'b0);
    wait_for(1, 1'b1);
    `CHK(lnk_if.bit_clk_oe, 1'b1)
    `CHK(test_mode, 1'b0)
    wait_for(2, 1'b1);
    // Long enough for two whole frames
    repeat (1100) @(negedge clk_sys);
    $display("Test startup and frames done");

    pulse(0, 1'b0, 2'h0);
    pulse(0, 1'b0, 2'h1);
    `CHK(lnk_if.bit_clk_oe, 1'b0)
    wait_for(0, 1'b0);
    wait_for(1, 1'b1);
    // Let the controller see a few edges, still short of the settle time
    repeat (3 + $urandom % 3) @(negedge clk_sys);
    pulse(0, 1'b0, 2'h1);
    wait_for(2, 1'b1);
    pulse(1, 1'b0, 2'h1);
    $display("Test refusals done");

    // Park only in the low part of a frame, so sync is not frozen high
    wait_for(3, 1'b1);
    wait_for(3, 1'b0);
    clk_stop_req = 1'b1;
    wait_for(1, 1'b0);
    clk_stop_req = 1'b0;
    `CHK(lnk_if.bit_clk, 1'b0)
    repeat (12) @(negedge clk_sys);
    pulse(1, 1'b0, 2'h2);
    wait_for(0, 1'b0);
    wait_for(1, 1'b1);
    wait_for(2, 1'b1);
    $display("Test park and warm wake done");

    for (int i = 0; i < 4; i++) begin
      t = (i == 3) ? 1'b0 : ((i == 0) ? 1'b1 : 1'($urandom % 2));
      pulse(0, t, 2'h0);
      `CHK(lnk_if.bit_clk_oe, 1'b0)
      wait_for(0, 1'b0);
      repeat (8) @(negedge clk_sys);
      `CHK(test_mode, t)
      `CHK(lnk_if.bit_clk_oe, ~t)
      if (t == 1'b0) begin
        wait_for(2, 1'b1);
      end
    end
    `CHK(notes.size(), 0)
    $display("Test cold and test-mode resets done");
    close_out();
  end
endmodule
`default_nettype wire
